/* src/eeprom_access_pkg.sv */
package eeprom_access_pkg;
   // i/o register offsets; only the low address byte has a printed location
   localparam logic [5:0] ADDR_LOW_OFFSET = 6'h1E;
   localparam logic [5:0] ADDR_HIGH_OFFSET = 6'h1F;
   localparam logic [5:0] DATA_BYTE_OFFSET = 6'h1D;
   localparam logic [5:0] CONTROL_OFFSET = 6'h1C;

   // control register bit positions
   localparam int READ_STROBE_BIT = 0;
   localparam int PROGRAM_ENABLE_BIT = 1;
   localparam int MASTER_ENABLE_BIT = 2;
   localparam int READY_IRQ_BIT = 3;
   localparam int PROG_MODE_LO_BIT = 4;
   localparam int PROG_MODE_HI_BIT = 5;

   // programming modes
   localparam logic [1:0] MODE_ATOMIC = 2'h0;
   localparam logic [1:0] MODE_ERASE = 2'h1;
   localparam logic [1:0] MODE_WRITE = 2'h2;
   localparam logic [1:0] MODE_RESERVED = 2'h3;
   localparam logic [1:0] PROG_MODE_RESET = 2'h0;

   // master enable window and processor stalls, in clocks
   localparam int MASTER_WINDOW_CYCLES = 4;
   localparam int PROG_STALL_CYCLES = 2;
   localparam int READ_STALL_CYCLES = 4;

   // programming times in microseconds, derived from the calibrated tick
   localparam int ATOMIC_TIME_US = 3400;
   localparam int SPLIT_TIME_US = 1800;
   localparam int CLOCK_MHZ = 250;
   localparam int TICK_CYCLES = CLOCK_MHZ;
   localparam int ATOMIC_TICKS = ATOMIC_TIME_US;
   localparam int SPLIT_TICKS = SPLIT_TIME_US;
   localparam int ATOMIC_CYCLES = ATOMIC_TIME_US * CLOCK_MHZ;
   localparam int SPLIT_CYCLES = SPLIT_TIME_US * CLOCK_MHZ;
endpackage

/* src/eeprom_array_if.sv */
`timescale 1ns/1ps
interface eeprom_array_if #(
   parameter int ADDR_WIDTH = 9
);
   logic rd_en;
   logic [ADDR_WIDTH-1:0] addr;
   logic [7:0] rd_data;
   logic prog_start;
   logic [1:0] prog_mode;
   logic [7:0] wr_data;
   logic prog_done;

   modport ctrl (
      output rd_en,
      output addr,
      input rd_data,
      output prog_start,
      output prog_mode,
      output wr_data,
      input prog_done
   );
   modport array (
      input rd_en,
      input addr,
      output rd_data,
      input prog_start,
      input prog_mode,
      input wr_data,
      output prog_done
   );
endinterface

/* src/eeprom_prog_timer.sv */
`timescale 1ns/1ps
module eeprom_prog_timer
   import eeprom_access_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES,
   parameter int ATOMIC_N = ATOMIC_TICKS,
   parameter int SPLIT_N = SPLIT_TICKS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // calibrated oscillator tick
   input wire logic osc_tick,
   // start and length select
   input wire logic start,
   input wire logic atomic,
   // completion
   output logic done
);
   logic [23:0] ticks_left;
   logic [15:0] div_cnt;
   logic running;
   logic unit_tick;

   // one microsecond unit counted off the calibrated oscillator
   assign unit_tick = osc_tick && (div_cnt == 16'(TICK_DIV - 1));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 16'h0000;
      end else if (!running || unit_tick) begin
         div_cnt <= 16'h0000;
      end else if (osc_tick) begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // remaining time; started fresh on each request
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ticks_left <= 24'h000000;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            ticks_left <= atomic ? 24'(ATOMIC_N) : 24'(SPLIT_N);
            running <= 1'b1;
         end else if (running && unit_tick) begin
            if (ticks_left == 24'h000001) begin
               running <= 1'b0;
               done <= 1'b1;
            end
            ticks_left <= ticks_left - 24'h000001;
         end
      end
   end
endmodule

/* src/eeprom_array.sv */
`timescale 1ns/1ps
module eeprom_array #(
   parameter int ADDR_WIDTH = 9,
   parameter int TICK_DIV = 250,
   parameter int ATOMIC_N = 3400,
   parameter int SPLIT_N = 1800
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic osc_tick,
   // controller side
   eeprom_array_if.array port
);
   logic [7:0] mem [0:(1<<ADDR_WIDTH)-1];
   logic [ADDR_WIDTH-1:0] hold_addr;
   logic [7:0] hold_data;
   logic [1:0] hold_mode;
   logic done;

   // programming time comes from the calibrated tick
   eeprom_prog_timer #(
      .TICK_DIV(TICK_DIV),
      .ATOMIC_N(ATOMIC_N),
      .SPLIT_N(SPLIT_N)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .osc_tick(osc_tick),
      .start(port.prog_start),
      .atomic(port.prog_mode == 2'h0),
      .done(done)
   );
   assign port.prog_done = done;

   // latch the job at start; commit the cell when time is up
   always_ff @(posedge sys_clk) begin
      if (port.prog_start) begin
         hold_addr <= port.addr;
         hold_data <= port.wr_data;
         hold_mode <= port.prog_mode;
      end
      if (done) begin
         // erase leaves all ones; write only can clear bits, never set
         if (hold_mode == 2'h0) begin
            mem[hold_addr] <= hold_data;
         end else if (hold_mode == 2'h1) begin
            mem[hold_addr] <= 8'hFF;
         end else begin
            mem[hold_addr] <= mem[hold_addr] & hold_data;
         end
      end
   end

   // combinational read: the strobe edge itself must capture the addressed byte,
   // a registered read here would hand the data byte last strobe's value
   assign port.rd_data = port.rd_en ? mem[port.addr] : 8'h00;
endmodule

/* src/eeprom_access_controller.sv */
// Contract
// - master program enable clears itself four clocks after software sets it
// - program enable starts only while master enable is still set
// - mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved
// - a valid program enable write performs the selected mode
// - program enable stays set while busy, cleared when time elapses
// - setting program enable stalls the processor two clocks
// - writes to the mode field are dropped while program enable is set
// - core reset clears the mode field unless programming is in progress
// - ready interrupt is a level while enabled, global flag set, and idle
// - read strobe loads the data byte at once, stalling four clocks
// - while programming, reads are blocked and address cannot change
// - core reset does not abort a programming operation in progress
// - bytes are addressed linearly; bits above the array size read zero
// - data byte supplies write data and holds the byte read back
// - high address bits seven to one always read zero
// - programming durations are timed from the calibrated oscillator
`timescale 1ns/1ps
module eeprom_access_controller
   import eeprom_access_pkg::*;
#(
   parameter int ADDR_WIDTH = 9,
   parameter int TICK_DIV = TICK_CYCLES,
   parameter int ATOMIC_N = ATOMIC_TICKS,
   parameter int SPLIT_N = SPLIT_TICKS
) (
   // clock and resets
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cpu_rst_n,
   // calibrated oscillator tick
   input wire logic osc_tick,
   // i/o register bus from the core
   input wire logic [5:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // global interrupt flag from the core flags register
   input wire logic global_irq_enable,
   // to the core
   output logic cpu_stall,
   output logic ready_irq
);
   eeprom_array_if #(.ADDR_WIDTH(ADDR_WIDTH)) arr ();

   logic [ADDR_WIDTH-1:0] byte_address_reg;
   logic [7:0] byte_data_reg;
   logic [1:0] prog_mode_field;
   logic ready_irq_enable;
   logic master_program_enable;
   logic program_enable;
   logic [2:0] master_cnt;
   logic [2:0] stall_cnt;
   logic wr_ctrl, wr_alow, wr_ahigh, wr_data;
   logic prog_go, read_go;
   logic [7:0] ctrl_view, ahigh_view, alow_view;

   // register write decode
   always_comb begin
      wr_ctrl = 1'b0;
      wr_alow = 1'b0;
      wr_ahigh = 1'b0;
      wr_data = 1'b0;
      if (io_wr && io_addr == CONTROL_OFFSET) begin
         wr_ctrl = 1'b1;
      end else if (io_wr && io_addr == ADDR_LOW_OFFSET) begin
         wr_alow = 1'b1;
      end else if (io_wr && io_addr == ADDR_HIGH_OFFSET) begin
         wr_ahigh = 1'b1;
      end else if (io_wr && io_addr == DATA_BYTE_OFFSET) begin
         wr_data = 1'b1;
      end
   end

   // a start needs the master enable still live and the array idle
   assign prog_go = wr_ctrl && io_wdata[PROGRAM_ENABLE_BIT] && master_program_enable
      && !program_enable && prog_mode_field != MODE_RESERVED;
   // reads are refused while programming
   assign read_go = wr_ctrl && io_wdata[READ_STROBE_BIT] && !program_enable;

   // master enable: set by software, dropped after the window
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         master_program_enable <= 1'b0;
         master_cnt <= 3'h0;
      end else if (!cpu_rst_n) begin
         master_program_enable <= 1'b0;
         master_cnt <= 3'h0;
      end else if (wr_ctrl && io_wdata[MASTER_ENABLE_BIT]) begin
         master_program_enable <= 1'b1;
         master_cnt <= 3'(MASTER_WINDOW_CYCLES - 1);
      end else if (master_program_enable) begin
         if (master_cnt == 3'h0) begin
            master_program_enable <= 1'b0;
         end
         master_cnt <= master_cnt - 3'h1;
      end
   end

   // program enable: only the power-on reset can drop a running job
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         program_enable <= 1'b0;
      end else if (prog_go) begin
         program_enable <= 1'b1;
      end else if (arr.prog_done) begin
         program_enable <= 1'b0;
      end
   end

   // mode field frozen while busy; core reset spares a busy array
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_mode_field <= PROG_MODE_RESET;
      end else if (!cpu_rst_n) begin
         if (!program_enable) begin
            prog_mode_field <= PROG_MODE_RESET;
         end
      end else if (wr_ctrl && !program_enable) begin
         prog_mode_field <= io_wdata[PROG_MODE_HI_BIT:PROG_MODE_LO_BIT];
      end
   end

   // interrupt enable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_irq_enable <= 1'b0;
      end else if (!cpu_rst_n) begin
         ready_irq_enable <= 1'b0;
      end else if (wr_ctrl) begin
         ready_irq_enable <= io_wdata[READY_IRQ_BIT];
      end
   end

   // address: undefined at reset, locked while programming
   always_ff @(posedge sys_clk) begin
      if (wr_alow && !program_enable) begin
         byte_address_reg[7:0] <= io_wdata;
      end
      if (wr_ahigh && !program_enable && ADDR_WIDTH > 8) begin
         byte_address_reg[ADDR_WIDTH-1] <= io_wdata[0];
      end
   end

   // data byte: software write, or fetched byte after a read strobe
   always_ff @(posedge sys_clk) begin
      if (read_go) begin
         byte_data_reg <= arr.rd_data;
      end else if (wr_data) begin
         byte_data_reg <= io_wdata;
      end
   end

   // array interface; read is combinational through the cell array
   assign arr.rd_en = read_go;
   assign arr.addr = byte_address_reg;
   assign arr.prog_start = prog_go;
   assign arr.prog_mode = prog_mode_field;
   assign arr.wr_data = byte_data_reg;

   eeprom_array #(
      .ADDR_WIDTH(ADDR_WIDTH),
      .TICK_DIV(TICK_DIV),
      .ATOMIC_N(ATOMIC_N),
      .SPLIT_N(SPLIT_N)
   ) u_array (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .osc_tick(osc_tick),
      .port(arr)
   );

   // processor stall: two after a start, four after a read
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stall_cnt <= 3'h0;
      end else if (read_go) begin
         stall_cnt <= 3'(READ_STALL_CYCLES);
      end else if (prog_go) begin
         stall_cnt <= 3'(PROG_STALL_CYCLES);
      end else if (stall_cnt != 3'h0) begin
         stall_cnt <= stall_cnt - 3'h1;
      end
   end
   assign cpu_stall = stall_cnt != 3'h0;

   // level interrupt while idle
   assign ready_irq = ready_irq_enable && global_irq_enable && !program_enable;

   // read views; unused bits are zero
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[PROG_MODE_HI_BIT:PROG_MODE_LO_BIT] = prog_mode_field;
      ctrl_view[READY_IRQ_BIT] = ready_irq_enable;
      ctrl_view[MASTER_ENABLE_BIT] = master_program_enable;
      ctrl_view[PROGRAM_ENABLE_BIT] = program_enable;
      ahigh_view = 8'h00;
      alow_view = byte_address_reg[7:0];
      if (ADDR_WIDTH > 8) begin
         ahigh_view[0] = byte_address_reg[ADDR_WIDTH-1];
      end
      if (ADDR_WIDTH < 8) begin
         alow_view[7] = 1'b0;
      end
   end

   // read data registered; unmapped addresses return zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_rdata <= 8'h00;
      end else if (!io_rd) begin
         io_rdata <= 8'h00;
      end else if (io_addr == CONTROL_OFFSET) begin
         io_rdata <= ctrl_view;
      end else if (io_addr == ADDR_LOW_OFFSET) begin
         io_rdata <= alow_view;
      end else if (io_addr == ADDR_HIGH_OFFSET) begin
         io_rdata <= ahigh_view;
      end else if (io_addr == DATA_BYTE_OFFSET) begin
         io_rdata <= byte_data_reg;
      end else begin
         io_rdata <= 8'h00;
      end
   end
endmodule

/* dv/eeprom_access_chk.sv */
`timescale 1ns/1ps
module eeprom_access_chk
   import eeprom_access_pkg::*;
#(
   parameter int ADDR_WIDTH = 9,
   parameter int TICK_DIV = TICK_CYCLES,
   parameter int ATOMIC_N = ATOMIC_TICKS,
   parameter int SPLIT_N = SPLIT_TICKS
) (
   // clock and resets
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cpu_rst_n,
   input wire logic osc_tick,
   // register bus
   input wire logic [5:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // core side
   input wire logic global_irq_enable,
   input wire logic cpu_stall,
   input wire logic ready_irq
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // decoded control accesses; ready_irq doubles as idle flag while enabled
   wire ctl_rd = io_rd && io_addr == CONTROL_OFFSET;
   wire ctl_wr = io_wr && io_addr == CONTROL_OFFSET;
   wire arm_wr = ctl_wr && io_wdata[2] && !io_wdata[1] && io_wdata[5:4] != MODE_RESERVED;
   wire go_wr = ctl_wr && io_wdata[1] && !io_wdata[0] && io_wdata[5:4] != MODE_RESERVED;

   property p_master_on;
      arm_wr ##1 (!io_wr) [*3] ##1 ctl_rd |=> io_rdata[2];
   endproperty
   a_master_on: assert property (p_master_on) else $error("master enable lost early");
   property p_master_off;
      arm_wr ##1 (!io_wr) [*5] ##1 ctl_rd |=> !io_rdata[2];
   endproperty
   a_master_off: assert property (p_master_off) else $error("master enable stuck");
   property p_go;
      (arm_wr && ready_irq) ##[1:4] (go_wr && io_wdata[3] && global_irq_enable)
         |=> (cpu_stall && !ready_irq) [*2] ##1 !cpu_stall;
   endproperty
   a_go: assert property (p_go) else $error("program start stall wrong");
   property p_late;
      (arm_wr && ready_irq) ##5 go_wr |=> !cpu_stall;
   endproperty
   a_late: assert property (p_late) else $error("late start accepted");
   property p_rd_stall;
      (ctl_wr && io_wdata[0] && !io_wdata[1] && ready_irq) |=> cpu_stall [*4] ##1 !cpu_stall;
   endproperty
   a_rd_stall: assert property (p_rd_stall) else $error("read stall wrong");
   property p_hi_zero;
      io_rd && io_addr == ADDR_HIGH_OFFSET |=> io_rdata[7:1] == 7'h00;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("high address bits set");
   property p_irq_gate;
      ready_irq |-> global_irq_enable;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without global flag");
   property p_rst;
      $rose(rst_n) |-> !cpu_stall && !ready_irq && io_rdata == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   // main scenarios reached
   c_go: cover property (go_wr);
   c_rd: cover property (ctl_rd);
   c_busy: cover property ($fell(ready_irq));
endmodule

/* dv/core_bus.sv */
`timescale 1ns/1ps
module core_bus
   import eeprom_access_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // register bus to the block
   output logic [5:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // halt request
   input wire logic cpu_stall
);
   // bus idle at time zero
   initial begin
      io_addr = 6'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // a halted core issues nothing
   task automatic hold_off();
      while (cpu_stall) begin
         @(posedge sys_clk);
         #1;
      end
   endtask
   // released lines show inverted values so a stale latch is caught
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      hold_off();
      @(posedge sys_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge sys_clk);
      io_wr <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      hold_off();
      @(posedge sys_clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge sys_clk);
      io_rd <= 1'b0;
      io_addr <= ~a;
      #1;
      d = io_rdata;
   endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench
   import eeprom_access_pkg::*;
;
   // programming times scaled down: 10 and 6 clocks
   localparam int TD = 2;
   localparam int AN = 5;
   localparam int SN = 3;
   localparam logic [5:0] CT = CONTROL_OFFSET;
   localparam logic [5:0] DB = DATA_BYTE_OFFSET;
   localparam logic [7:0] WDAT [3] = '{8'hA5, 8'h00, 8'h3C};
   localparam logic [7:0] XDAT [3] = '{8'hA5, 8'hFF, 8'h3C};
   logic sys_clk, rst_n, cpu_rst_n, osc_tick, osc_slow, gie, io_wr, io_rd, cpu_stall, ready_irq;
   logic [5:0] io_addr;
   logic [7:0] io_wdata, io_rdata;
   int error_cnt, compares, cyc_cnt;

   eeprom_access_controller #(.ADDR_WIDTH(9), .TICK_DIV(TD), .ATOMIC_N(AN), .SPLIT_N(SN))
   u_eeprom_access_controller (
      .sys_clk, .rst_n, .cpu_rst_n, .osc_tick, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
      .global_irq_enable(gie), .cpu_stall, .ready_irq
   );
   core_bus u_core_bus (.sys_clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .cpu_stall);

   // 250 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // calibrated tick: every clock, or every other clock when slowed
   always @(posedge sys_clk) begin
      osc_tick <= !osc_slow || !osc_tick;
   end
   // hang guard, far above the few hundred clocks needed
   initial cyc_cnt = 0;
   always @(posedge sys_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (error_cnt == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [5:0] a, input logic [7:0] d);
      u_core_bus.wr(a, d);
   endtask
   task automatic rc(input logic [5:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
      logic [7:0] v;
      u_core_bus.rd(a, v);
      chk(v & m, exp);
   endtask
   // arm master enable, then start after gap plus one idle clocks
   task automatic prog(input logic [1:0] m, input int gap);
      w(CT, {2'b00, m, 4'b1100});
      repeat (gap) @(posedge sys_clk);
      w(CT, {2'b00, m, 4'b1110});
   endtask
   // busy just before the nominal time, idle a few clocks after
   task automatic timed(input int cyc);
      repeat (cyc - 3) @(posedge sys_clk);
      rc(CT, 8'h02, 8'h02);
      repeat (4) @(posedge sys_clk);
      rc(CT, 8'h00, 8'h02);
   endtask
   task automatic wait_idle();
      logic [7:0] v;
      do begin
         u_core_bus.rd(CT, v);
      end while (v[1]);
   endtask
   task automatic core_reset();
      @(posedge sys_clk);
      cpu_rst_n <= 1'b0;
      @(posedge sys_clk);
      cpu_rst_n <= 1'b1;
      #1;
   endtask

   // main sequence
   initial begin
      error_cnt = 0;
      compares = 0;
      rst_n = 1'b0;
      cpu_rst_n = 1'b1;
      osc_slow = 1'b0;
      gie = 1'b1;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      rc(CT, 8'h00);
      chk({7'h00, ready_irq}, 8'h00);
      w(ADDR_HIGH_OFFSET, 8'hFF);
      rc(ADDR_HIGH_OFFSET, 8'h01);
      w(ADDR_HIGH_OFFSET, 8'h00);
      w(ADDR_LOW_OFFSET, 8'h05);
      // master enable readable for four clocks only
      w(CT, 8'h0C);
      rc(CT, 8'h04, 8'h04);
      rc(CT, 8'h04, 8'h04);
      rc(CT, 8'h00, 8'h04);
      chk({7'h00, ready_irq}, 8'h01);
      prog(MODE_ATOMIC, 3);
      rc(CT, 8'h00, 8'h02);
      // every mode; erase comes before write only
      for (int i = 0; i < 3; i++) begin
         w(DB, WDAT[i]);
         prog(i[1:0], i == 0 ? 2 : 0);
         timed(i == 0 ? AN * TD : SN * TD);
         w(CT, 8'h09);
         rc(DB, XDAT[i]);
      end
      prog(MODE_RESERVED, 0);
      rc(CT, 8'h00, 8'h02);
      // while busy, mode, address and read strobe writes are dropped
      prog(MODE_ATOMIC, 0);
      chk({7'h00, ready_irq}, 8'h00);
      w(ADDR_LOW_OFFSET, 8'h09);
      w(CT, 8'h1B);
      rc(CT, 8'h0A, 8'hFE);
      wait_idle();
      rc(ADDR_LOW_OFFSET, 8'h05);
      rc(DB, 8'h3C);
      w(CT, 8'h09);
      rc(DB, 8'h3C);
      // interrupt gated by the global flag and its own enable
      chk({7'h00, ready_irq}, 8'h01);
      @(posedge sys_clk);
      gie <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk({7'h00, ready_irq}, 8'h00);
      @(posedge sys_clk);
      gie <= 1'b1;
      w(CT, 8'h00);
      chk({7'h00, ready_irq}, 8'h00);
      // core reset mid-erase keeps the job and its mode
      prog(MODE_ERASE, 0);
      core_reset();
      rc(CT, 8'h12, 8'hFE);
      wait_idle();
      core_reset();
      rc(CT, 8'h00);
      w(CT, 8'h01);
      rc(DB, 8'hFF);
      // half-rate oscillator must double the erase time
      osc_slow <= 1'b1;
      prog(MODE_ERASE, 0);
      timed(SN * TD * 2);
      end_sim();
   end
endmodule

bind eeprom_access_controller eeprom_access_chk #(
   .ADDR_WIDTH(ADDR_WIDTH), .TICK_DIV(TICK_DIV), .ATOMIC_N(ATOMIC_N), .SPLIT_N(SPLIT_N)
) u_eeprom_access_chk (
   .sys_clk, .rst_n, .cpu_rst_n, .osc_tick, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
   .global_irq_enable, .cpu_stall, .ready_irq
);
